// >>> sct_pkg.sv
// Constants shared by the split compare timer and its helpers.
// Assumes one core clock at 125 MHz and an 8-bit register port.
// Summary of operation
// - Bit 5 gates high overflow interrupt.
// - Bit 4 clears counter on match.
// - Bit 3 set on low overflow.
// - Flags clear by zero after read-one.
// - Bit 2 set on low match.
// - Bit 1 gates low overflow interrupt.
// - Bit 0 clears low counter on match when split.
// - Reset counter zero, compare all ones.
// - High select msb zero: one 16-bit timer.
// - Low select picks source, high carries.
// - Wide match sets flag, toggles, interrupts.
// - Wide rollover sets high overflow flag.
// - High select msb one: two halves.
// - Each half matches, flags, toggles, clears.
// - Each half rollover sets its flag.
// - Sources: core /32, /16, /4, sub /4.
// - Low msb zero counts chosen event edge.
// - Pin drives written level until match.
// - Pin inverts on its match; low pin only when split.
// - Select codes map to sources.
// - Match fires when counter leaves value.
package sct_pkg;
	localparam int          SCT_ADDR_W      = 3;
	localparam logic [2:0]  SCT_OFF_CTRL    = 3'h0;
	localparam logic [2:0]  SCT_OFF_CSR     = 3'h1;
	localparam logic [2:0]  SCT_OFF_HI_CNT  = 3'h2;
	localparam logic [2:0]  SCT_OFF_LO_CNT  = 3'h3;
	localparam logic [2:0]  SCT_OFF_HI_CMP  = 3'h4;
	localparam logic [2:0]  SCT_OFF_LO_CMP  = 3'h5;
	localparam logic [2:0]  SCT_OFF_IEN     = 3'h6;
	localparam logic [2:0]  SCT_OFF_EDGE    = 3'h7;
	// Status bit positions
	localparam int          SCT_HI_OVF_FLAG = 7;
	localparam int          SCT_HI_MT_FLAG  = 6;
	localparam int          SCT_HI_OVF_IE   = 5;
	localparam int          SCT_HI_MT_CLR   = 4;
	localparam int          SCT_LO_OVF_FLAG = 3;
	localparam int          SCT_LO_MT_FLAG  = 2;
	localparam int          SCT_LO_OVF_IE   = 1;
	localparam int          SCT_LO_MT_CLR   = 0;
	localparam logic [7:0]  SCT_FLAG_MASK   = 8'hcc;
	// Control register fields, then interrupt enable and edge register bits
	localparam int          SCT_HI_LEVEL    = 7;
	localparam int          SCT_HI_SEL_LSB  = 4;
	localparam int          SCT_LO_LEVEL    = 3;
	localparam int          SCT_LO_SEL_LSB  = 0;
	localparam int          SCT_IEN_HI      = 1;
	localparam int          SCT_IEN_LO      = 0;
	localparam int          SCT_EDGE_BIT    = 0;
	// Reset values and counter top value
	localparam logic [7:0]  SCT_REG_RST     = 8'h00;
	localparam logic [7:0]  SCT_CNT_RST     = 8'h00;
	localparam logic [7:0]  SCT_CMP_RST     = 8'hff;
	localparam logic [7:0]  SCT_CNT_TOP     = 8'hff;
	// Divider counts, and number of prescaler tick sources
	localparam int          SCT_DIV_WIDE    = 32;
	localparam int          SCT_DIV_MID     = 16;
	localparam int          SCT_DIV_FAST    = 4;
	localparam int          SCT_DIV_SUB     = 4;
	localparam int          SCT_SRC_N       = 4;
endpackage

// >>> sct_pin_edge.sv
// Three-stage synchroniser with edge pulses for an asynchronous pin.
// Assumes the pin holds each level for more than two core clocks.
`timescale 1ns/1ns
module sct_pin_edge (
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_arst_n,
	// Pin and edges
	input  wire logic i_pin,
	output logic      o_rise,
	output logic      o_fall
);
	import sct_pkg::*;
	typedef struct packed {
		logic [2:0] sync;
		logic       level;
		logic       rise;
		logic       fall;
	} sct_edge_t;
	sct_edge_t st_reg, st_next;

	// Only stages two and three are compared; stage one feeds stage two alone
	always_comb begin
		st_next      = st_reg;
		st_next.sync = {st_reg.sync[1:0], i_pin};
		st_next.rise = 1'b0;
		st_next.fall = 1'b0;
		if (st_reg.sync[1] == st_reg.sync[2] && st_reg.sync[2] != st_reg.level) begin
			st_next.level = st_reg.sync[2];
			st_next.rise  = st_reg.sync[2];
			st_next.fall  = ~st_reg.sync[2];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_rise = st_reg.rise;
	assign o_fall = st_reg.fall;
endmodule

// >>> sct_prescale.sv
// Core clock divider and subclock quarterer giving one-cycle count ticks.
// Assumes the subclock rising edges arrive as one-cycle pulses.
`timescale 1ns/1ns
module sct_prescale (
	// Clock and reset
	input  wire logic                          i_core_clk,
	input  wire logic                          i_arst_n,
	// Subclock edge
	input  wire logic                          i_sub_rise,
	// Ticks: 0 core/32, 1 core/16, 2 core/4, 3 sub/4
	output logic [sct_pkg::SCT_SRC_N-1:0]      o_tick
);
	import sct_pkg::*;
	typedef struct packed {
		logic [4:0]           div;
		logic [1:0]           sub;
		logic [SCT_SRC_N-1:0] tick;
	} sct_pre_t;
	sct_pre_t st_reg, st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.div  = st_reg.div + 5'h01;
		st_next.tick[0] = st_reg.div == 5'(SCT_DIV_WIDE - 1);
		st_next.tick[1] = st_reg.div[3:0] == 4'(SCT_DIV_MID - 1);
		st_next.tick[2] = st_reg.div[1:0] == 2'(SCT_DIV_FAST - 1);
		st_next.tick[3] = 1'b0;
		if (i_sub_rise) begin
			st_next.sub     = st_reg.sub + 2'h1;
			st_next.tick[3] = st_reg.sub == 2'(SCT_DIV_SUB - 1);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_tick = st_reg.tick;
endmodule

// >>> sct_timer.sv
// Split compare timer: 16-bit counter or two 8-bit counters with compare.
// Assumes a single-cycle register port and asynchronous event/subclock pins.
`timescale 1ns/1ns
module sct_timer (
	// Clock and reset
	input  wire logic                            i_core_clk,
	input  wire logic                            i_arst_n,
	// Register port
	input  wire logic [sct_pkg::SCT_ADDR_W-1:0]  i_addr,
	input  wire logic [7:0]                      i_wdata,
	input  wire logic                            i_wr,
	input  wire logic                            i_rd,
	output logic      [7:0]                      o_rdata,
	// Pins
	input  wire logic                            i_event_input_pin,
	input  wire logic                            i_sub_clk,
	output logic                                 o_hi_compare_out,
	output logic                                 o_lo_compare_out,
	// Interrupt requests
	output logic                                 o_hi_irq,
	output logic                                 o_lo_irq
);
	import sct_pkg::*;

	typedef struct packed {
		logic       hi_out_level;
		logic [2:0] hi_sel;
		logic       lo_out_level;
		logic [2:0] lo_sel;
		logic [7:0] csr;
		logic [7:0] armed;
		logic [7:0] upper_counter;
		logic [7:0] lower_counter;
		logic [7:0] upper_compare_reg;
		logic [7:0] lower_compare_reg;
		logic       hi_irq_enable;
		logic       lo_irq_enable;
		logic       event_edge_sel;
		logic       hi_out;
		logic       lo_out;
		logic       hi_irq;
		logic       lo_irq;
		logic [7:0] rdata;
	} sct_state_t;

	sct_state_t st_reg, st_next;

	logic                 ev_rise;
	logic                 ev_fall;
	logic                 sub_rise;
	logic [SCT_SRC_N-1:0] pre_tick;
	logic                 mode8;
	logic                 ev_tick;
	logic                 lo_tick;
	logic                 hi_tick;
	logic                 wr_ctrl;
	logic                 wr_csr;
	logic                 wr_hi;
	logic                 wr_lo;
	logic                 wr_hicmp;
	logic                 wr_locmp;
	logic                 lo_match;
	logic                 hi_match;
	logic                 lo_ovf;
	logic                 hi_ovf;
	logic                 hi_clr;
	logic                 lo_clr;
	logic [15:0]          wide_counter;
	logic [15:0]          wide_compare_reg;

	sct_pin_edge u_event (
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_pin      (i_event_input_pin),
		.o_rise     (ev_rise),
		.o_fall     (ev_fall)
	);

	sct_pin_edge u_sub (
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_pin      (i_sub_clk),
		.o_rise     (sub_rise),
		.o_fall     ()
	);

	sct_prescale u_pre (
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_sub_rise (sub_rise),
		.o_tick     (pre_tick)
	);

	// Select codes 0xx, including the forbidden 011, fall back to events
	function automatic logic src_tick(input logic [2:0] sel, input logic [SCT_SRC_N-1:0] tk,
	                                  input logic ev);
		src_tick = sel[2] ? tk[sel[1:0]] : ev;
	endfunction

	assign mode8            = st_reg.hi_sel[2];
	assign wide_counter     = {st_reg.upper_counter, st_reg.lower_counter};
	assign wide_compare_reg = {st_reg.upper_compare_reg, st_reg.lower_compare_reg};
	assign ev_tick  = st_reg.event_edge_sel ? ev_rise : ev_fall;
	assign lo_tick  = src_tick(st_reg.lo_sel, pre_tick, ev_tick);
	// In 16-bit mode the upper half counts carries of the lower half
	assign hi_tick  = mode8 ? src_tick(st_reg.hi_sel, pre_tick, ev_tick)
	                        : lo_tick && st_reg.lower_counter == SCT_CNT_TOP;

	assign wr_ctrl  = i_wr && i_addr == SCT_OFF_CTRL;
	assign wr_csr   = i_wr && i_addr == SCT_OFF_CSR;
	assign wr_hi    = i_wr && i_addr == SCT_OFF_HI_CNT;
	assign wr_lo    = i_wr && i_addr == SCT_OFF_LO_CNT;
	assign wr_hicmp = i_wr && i_addr == SCT_OFF_HI_CMP;
	assign wr_locmp = i_wr && i_addr == SCT_OFF_LO_CMP;

	// A match is seen on the count tick that leaves the matching value,
	// and a compare write in that cycle cancels it
	assign lo_match = lo_tick && !wr_locmp &&
	                  st_reg.lower_counter == st_reg.lower_compare_reg;
	assign hi_match = mode8 ? (hi_tick && !wr_hicmp &&
	                           st_reg.upper_counter == st_reg.upper_compare_reg)
	                        : (lo_tick && !wr_hicmp && !wr_locmp &&
	                           wide_counter == wide_compare_reg);
	// A counter write in the overflow cycle swallows the overflow
	assign lo_ovf   = lo_tick && !wr_lo && st_reg.lower_counter == SCT_CNT_TOP;
	assign hi_ovf   = hi_tick && !wr_hi && (mode8 || !wr_lo) &&
	                  st_reg.upper_counter == SCT_CNT_TOP;
	assign hi_clr   = hi_match && st_reg.csr[SCT_HI_MT_CLR];
	assign lo_clr   = mode8 ? lo_match && st_reg.csr[SCT_LO_MT_CLR]
	                        : hi_clr;

	always_comb begin
		st_next       = st_reg;
		st_next.rdata = 8'h00;

		// Counting
		if (lo_clr)
			st_next.lower_counter = SCT_CNT_RST;
		else if (lo_tick)
			st_next.lower_counter = st_reg.lower_counter + 8'h01;
		if (hi_clr)
			st_next.upper_counter = SCT_CNT_RST;
		else if (hi_tick)
			st_next.upper_counter = st_reg.upper_counter + 8'h01;

		// Compare outputs: toggle on match, low pin only meaningful split
		if (hi_match)
			st_next.hi_out = ~st_reg.hi_out;
		if (lo_match && mode8)
			st_next.lo_out = ~st_reg.lo_out;

		// Interrupt request pulses
		st_next.hi_irq = st_reg.hi_irq_enable &&
		                 (hi_match || (hi_ovf && st_reg.csr[SCT_HI_OVF_IE]));
		st_next.lo_irq = st_reg.lo_irq_enable &&
		                 (lo_match || (lo_ovf && st_reg.csr[SCT_LO_OVF_IE]));

		// Register reads; a flag returned as one arms its clear
		if (i_rd) begin
			case (i_addr)
				SCT_OFF_CTRL:   st_next.rdata = {st_reg.hi_out_level, st_reg.hi_sel,
				                                 st_reg.lo_out_level, st_reg.lo_sel};
				SCT_OFF_CSR: begin
					st_next.rdata = st_reg.csr;
					st_next.armed = st_reg.armed | (st_reg.csr & SCT_FLAG_MASK);
				end
				SCT_OFF_HI_CNT: st_next.rdata = st_reg.upper_counter;
				SCT_OFF_LO_CNT: st_next.rdata = st_reg.lower_counter;
				SCT_OFF_HI_CMP: st_next.rdata = st_reg.upper_compare_reg;
				SCT_OFF_LO_CMP: st_next.rdata = st_reg.lower_compare_reg;
				SCT_OFF_IEN: begin
					st_next.rdata[SCT_IEN_HI] = st_reg.hi_irq_enable;
					st_next.rdata[SCT_IEN_LO] = st_reg.lo_irq_enable;
				end
				SCT_OFF_EDGE:   st_next.rdata[SCT_EDGE_BIT] = st_reg.event_edge_sel;
				default:        st_next.rdata = 8'h00;
			endcase
		end

		// Register writes
		if (i_wr) begin
			case (i_addr)
				SCT_OFF_CTRL: begin
					// A level write beats a match toggle in the same cycle
					st_next.hi_out_level = i_wdata[SCT_HI_LEVEL];
					st_next.hi_sel       = i_wdata[SCT_HI_SEL_LSB +: 3];
					st_next.lo_out_level = i_wdata[SCT_LO_LEVEL];
					st_next.lo_sel       = i_wdata[SCT_LO_SEL_LSB +: 3];
					st_next.hi_out       = i_wdata[SCT_HI_LEVEL];
					st_next.lo_out       = i_wdata[SCT_LO_LEVEL];
				end
				SCT_OFF_CSR: begin
					st_next.csr = (st_reg.csr & SCT_FLAG_MASK) |
					              (i_wdata & ~SCT_FLAG_MASK);
					// Zero clears an armed flag; one never sets it
					st_next.csr = st_next.csr &
					              ~(SCT_FLAG_MASK & st_reg.armed & ~i_wdata);
				end
				SCT_OFF_HI_CNT: st_next.upper_counter     = i_wdata;
				SCT_OFF_LO_CNT: st_next.lower_counter     = i_wdata;
				SCT_OFF_HI_CMP: st_next.upper_compare_reg = i_wdata;
				SCT_OFF_LO_CMP: st_next.lower_compare_reg = i_wdata;
				SCT_OFF_IEN: begin
					st_next.hi_irq_enable = i_wdata[SCT_IEN_HI];
					st_next.lo_irq_enable = i_wdata[SCT_IEN_LO];
				end
				SCT_OFF_EDGE:   st_next.event_edge_sel = i_wdata[SCT_EDGE_BIT];
				default:        st_next.event_edge_sel = st_reg.event_edge_sel;
			endcase
		end

		// Hardware sets after the clear so an event in the clear cycle is kept
		if (hi_ovf)
			st_next.csr[SCT_HI_OVF_FLAG] = 1'b1;
		if (hi_match)
			st_next.csr[SCT_HI_MT_FLAG] = 1'b1;
		if (lo_ovf)
			st_next.csr[SCT_LO_OVF_FLAG] = 1'b1;
		if (lo_match)
			st_next.csr[SCT_LO_MT_FLAG] = 1'b1;
		st_next.armed = st_next.armed & st_next.csr;
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg                   <= '0;
			st_reg.csr               <= SCT_REG_RST;
			st_reg.upper_counter     <= SCT_CNT_RST;
			st_reg.lower_counter     <= SCT_CNT_RST;
			st_reg.upper_compare_reg <= SCT_CMP_RST;
			st_reg.lower_compare_reg <= SCT_CMP_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rdata          = st_reg.rdata;
	assign o_hi_compare_out = st_reg.hi_out;
	assign o_lo_compare_out = st_reg.lo_out;
	assign o_hi_irq         = st_reg.hi_irq;
	assign o_lo_irq         = st_reg.lo_irq;

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	// Flags
	a_lo_ovf_flag: assert property (
		lo_ovf |=> st_reg.csr[SCT_LO_OVF_FLAG])
		else $error("low overflow flag not set");

	a_lo_match_flag: assert property (
		lo_match |=> st_reg.csr[SCT_LO_MT_FLAG])
		else $error("low match flag not set");

	a_hi_ovf_flag: assert property (
		hi_ovf |=> st_reg.csr[SCT_HI_OVF_FLAG])
		else $error("high overflow flag not set");

	a_hi_match_flag: assert property (
		hi_match |=> st_reg.csr[SCT_HI_MT_FLAG] && o_hi_irq == $past(st_reg.hi_irq_enable))
		else $error("high match flag or request wrong");

	a_no_set_by_one: assert property (
		wr_csr && !hi_ovf && !st_reg.csr[SCT_HI_OVF_FLAG] |=> !st_reg.csr[SCT_HI_OVF_FLAG])
		else $error("flag set by software write");

	a_flag_hold: assert property (
		!wr_csr && st_reg.csr[SCT_LO_OVF_FLAG] |=> st_reg.csr[SCT_LO_OVF_FLAG])
		else $error("flag dropped without a write");

	a_armed_clear: assert property (
		wr_csr && st_reg.armed[SCT_LO_MT_FLAG] && !i_wdata[SCT_LO_MT_FLAG] && !lo_match |=>
		!st_reg.csr[SCT_LO_MT_FLAG])
		else $error("armed flag not cleared by zero");

	// Requests
	a_hi_ovf_gate: assert property (
		hi_ovf && !hi_match |=>
		o_hi_irq == ($past(st_reg.csr[SCT_HI_OVF_IE]) && $past(st_reg.hi_irq_enable)))
		else $error("high overflow request gating wrong");

	a_hi_ovf_quiet: assert property (
		hi_ovf && !hi_match && !st_reg.csr[SCT_HI_OVF_IE] |=> !o_hi_irq)
		else $error("high overflow request without enable");

	a_lo_ovf_gate: assert property (
		lo_ovf && !lo_match |=>
		o_lo_irq == ($past(st_reg.csr[SCT_LO_OVF_IE]) && $past(st_reg.lo_irq_enable)))
		else $error("low overflow request gating wrong");

	a_lo_irq_match: assert property (
		lo_match |=> o_lo_irq == $past(st_reg.lo_irq_enable))
		else $error("low match request wrong");

	// Counters
	a_hi_clear: assert property (
		hi_clr && !wr_hi |=> st_reg.upper_counter == SCT_CNT_RST)
		else $error("high counter not cleared on match");

	a_wide_clear_all: assert property (
		!mode8 && hi_clr && !wr_lo |=> st_reg.lower_counter == SCT_CNT_RST)
		else $error("low half kept on wide clear");

	a_lo_clear: assert property (
		mode8 && lo_match && !st_reg.csr[SCT_LO_MT_CLR] && !wr_lo |=>
		st_reg.lower_counter == $past(st_reg.lower_counter) + 8'h01)
		else $error("low counter cleared without enable");

	a_split_lo_kept: assert property (
		mode8 && hi_clr && !lo_clr && lo_tick && !wr_lo |=>
		st_reg.lower_counter == $past(st_reg.lower_counter) + 8'h01)
		else $error("high clear touched low half");

	a_wide_carry: assert property (
		!mode8 && hi_tick && !hi_clr && !wr_hi |=>
		st_reg.upper_counter == $past(st_reg.upper_counter) + 8'h01)
		else $error("upper half missed carry");

	a_mode_select: assert property (
		wr_ctrl |=> mode8 == $past(i_wdata[SCT_HI_SEL_LSB + 2]))
		else $error("mode does not follow select msb");

	// Compare pins
	a_level_write: assert property (
		wr_ctrl |=> o_hi_compare_out == $past(i_wdata[SCT_HI_LEVEL]))
		else $error("compare pin did not take written level");

	a_toggle_match: assert property (
		hi_match && !wr_ctrl |=> o_hi_compare_out != $past(o_hi_compare_out))
		else $error("compare pin did not toggle");

	a_lo_toggle: assert property (
		mode8 && lo_match && !wr_ctrl |=> o_lo_compare_out != $past(o_lo_compare_out))
		else $error("low compare pin did not toggle");

	a_lo_pin_wide: assert property (
		!mode8 && !wr_ctrl |=> o_lo_compare_out == $past(o_lo_compare_out))
		else $error("low compare pin moved in wide mode");

	c_wide_match: cover property (!mode8 && hi_match && hi_clr);
	c_split_both: cover property (mode8 && hi_match ##[1:300] lo_match);
	c_flag_clear: cover property (wr_csr && |(st_reg.armed & ~i_wdata));
	c_event_count: cover property (!st_reg.lo_sel[2] && lo_tick);
	c_lo_toggle: cover property (mode8 && lo_match && !wr_ctrl);
endmodule

// >>> sct_pin_model.sv
// Far-side model: external event source and free-running subclock.
// Assumes the timer samples both pins through its own synchronisers.
`timescale 1ns/1ns
module sct_pin_model (
	// Clock
	input  wire logic i_core_clk,
	// Pins
	output logic      o_event_pin,
	output logic      o_sub_clk
);
	// Odd half period keeps subclock rising edges off core edges
	initial begin
		o_event_pin = 1'b0;
		o_sub_clk   = 1'b0;
		forever #103 o_sub_clk = ~o_sub_clk;
	end

	// Each pulse is held three core cycles high and at least three low
	task automatic send_pulses(input int n);
		repeat (n) begin
			@(posedge i_core_clk);
			#3 o_event_pin = 1'b1;
			repeat (3) @(posedge i_core_clk);
			#3 o_event_pin = 1'b0;
			repeat (3) @(posedge i_core_clk);
		end
	endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the split compare timer.
// Assumes the pin model drives events and the subclock.
`timescale 1ns/1ns
module testbench;
	import sct_pkg::*;
	logic                  i_core_clk;
	logic                  i_arst_n;
	logic [SCT_ADDR_W-1:0] i_addr;
	logic [7:0]            i_wdata;
	logic                  i_wr;
	logic                  i_rd;
	logic [7:0]            o_rdata;
	logic                  ev_pin;
	logic                  sub_clk;
	logic                  o_hi_compare_out;
	logic                  o_lo_compare_out;
	logic                  o_hi_irq;
	logic                  o_lo_irq;
	int                    n_errors;
	int                    checked;
	logic [7:0]            d;
	logic                  g;
	int                    n;

	sct_timer sct_timer_i (
		.i_core_clk        (i_core_clk),
		.i_arst_n          (i_arst_n),
		.i_addr            (i_addr),
		.i_wdata           (i_wdata),
		.i_wr              (i_wr),
		.i_rd              (i_rd),
		.o_rdata           (o_rdata),
		.i_event_input_pin (ev_pin),
		.i_sub_clk         (sub_clk),
		.o_hi_compare_out  (o_hi_compare_out),
		.o_lo_compare_out  (o_lo_compare_out),
		.o_hi_irq          (o_hi_irq),
		.o_lo_irq          (o_lo_irq)
	);

	sct_pin_model sct_pin_model_i (
		.i_core_clk  (i_core_clk),
		.o_event_pin (ev_pin),
		.o_sub_clk   (sub_clk)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end

	task automatic finish_test;
		$display("errors %0d, checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic do_reset;
		@(posedge i_core_clk);
		i_arst_n <= 1'b0;
		repeat (12) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge i_core_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= v;
		@(posedge i_core_clk);
		i_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge i_core_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd   <= 1'b0;
		#1 v = o_rdata;
	endtask

	// Counts cycles until the chosen request pulses, or gives up at max
	task automatic wait_irq(input logic hi, input int max, output logic got, output int cnt);
		cnt = 0;
		got = 1'b0;
		while (!got && cnt < max) begin
			@(posedge i_core_clk);
			#1 cnt++;
			got = hi ? (o_hi_irq === 1'b1) : (o_lo_irq === 1'b1);
		end
	endtask

	task automatic t_reset;
		logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
		do_reset();
		chk({4'h0, o_hi_compare_out, o_lo_compare_out, o_hi_irq, o_lo_irq}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), d);
			chk(d, exp[i]);
		end
	endtask

	task automatic t_levels;
		do_reset();
		wr(SCT_OFF_CTRL, 8'h88);
		repeat (2) @(posedge i_core_clk);
		#1 chk({6'h0, o_hi_compare_out, o_lo_compare_out}, 8'h03);
		wr(SCT_OFF_CTRL, 8'h00);
		repeat (2) @(posedge i_core_clk);
		#1 chk({6'h0, o_hi_compare_out, o_lo_compare_out}, 8'h00);
	endtask

	// Low half at match value 1 with clear: one request every two ticks
	task automatic t_split_lo;
		int divs [3] = '{SCT_DIV_WIDE, SCT_DIV_MID, SCT_DIV_FAST};
		for (int i = 0; i < 3; i++) begin
			do_reset();
			wr(SCT_OFF_LO_CMP, 8'h01);
			wr(SCT_OFF_CSR, 8'h01);
			wr(SCT_OFF_IEN, 8'h01);
			wr(SCT_OFF_CTRL, {4'h4, 1'b0, 3'(4 + i)});
			wait_irq(1'b0, 200, g, n);
			chk({7'h0, g}, 8'h01);
			chk({7'h0, o_lo_compare_out}, 8'h01);
			wait_irq(1'b0, 200, g, n);
			chk(8'(n), 8'(2 * divs[i]));
			chk({7'h0, o_lo_compare_out}, 8'h00);
			rd(SCT_OFF_CSR, d);
			chk(d & 8'h0f, 8'h05);
		end
	endtask

	task automatic t_flags;
		do_reset();
		wr(SCT_OFF_LO_CMP, 8'h80);
		wr(SCT_OFF_CSR, 8'h02);
		wr(SCT_OFF_IEN, 8'h01);
		wr(SCT_OFF_CTRL, 8'h46);
		wr(SCT_OFF_LO_CNT, 8'hfe);
		wait_irq(1'b0, 40, g, n);
		chk({7'h0, g}, 8'h01);
		// Clear without a prior read must not take
		wr(SCT_OFF_CSR, 8'h02);
		rd(SCT_OFF_CSR, d);
		chk(d, 8'h0a);
		wr(SCT_OFF_CSR, 8'h02);
		rd(SCT_OFF_CSR, d);
		chk(d, 8'h02);
		wr(SCT_OFF_CSR, 8'hce);
		rd(SCT_OFF_CSR, d);
		chk(d, 8'h02);
		wr(SCT_OFF_CSR, 8'h00);
		wr(SCT_OFF_LO_CNT, 8'hfe);
		wait_irq(1'b0, 40, g, n);
		chk({7'h0, g}, 8'h00);
		rd(SCT_OFF_CSR, d);
		chk(d, 8'h08);
	endtask

	task automatic t_wide;
		do_reset();
		wr(SCT_OFF_HI_CMP, 8'h12);
		wr(SCT_OFF_LO_CMP, 8'h34);
		wr(SCT_OFF_IEN, 8'h02);
		wr(SCT_OFF_CTRL, 8'h06);
		wr(SCT_OFF_HI_CNT, 8'hff);
		wr(SCT_OFF_LO_CNT, 8'hfd);
		wait_irq(1'b1, 40, g, n);
		chk({7'h0, g}, 8'h00);
		rd(SCT_OFF_CSR, d);
		chk(d & 8'hc0, 8'h80);
		rd(SCT_OFF_HI_CNT, d);
		chk(d, 8'h00);
		wr(SCT_OFF_CSR, 8'h20);
		wr(SCT_OFF_HI_CNT, 8'hff);
		wr(SCT_OFF_LO_CNT, 8'hfd);
		wait_irq(1'b1, 40, g, n);
		chk({7'h0, g}, 8'h01);
		wr(SCT_OFF_HI_CMP, 8'h00);
		wr(SCT_OFF_LO_CMP, 8'h05);
		wr(SCT_OFF_CSR, 8'h30);
		wait_irq(1'b1, 60, g, n);
		chk({7'h0, g}, 8'h01);
		chk({7'h0, o_hi_compare_out}, 8'h01);
		rd(SCT_OFF_HI_CNT, d);
		chk(d, 8'h00);
		rd(SCT_OFF_LO_CNT, d);
		chk({7'h0, d <= 8'h02}, 8'h01);
	endtask

	task automatic t_events;
		do_reset();
		wr(SCT_OFF_EDGE, 8'h01);
		sct_pin_model_i.send_pulses(5);
		repeat (8) @(posedge i_core_clk);
		rd(SCT_OFF_LO_CNT, d);
		chk(d, 8'h05);
		wr(SCT_OFF_EDGE, 8'h00);
		sct_pin_model_i.send_pulses(3);
		repeat (8) @(posedge i_core_clk);
		rd(SCT_OFF_LO_CNT, d);
		chk(d, 8'h08);
	endtask

	// Subclock jitter through the synchroniser allows a small spread
	task automatic t_sub;
		do_reset();
		wr(SCT_OFF_HI_CMP, 8'h01);
		wr(SCT_OFF_CSR, 8'h10);
		wr(SCT_OFF_IEN, 8'h02);
		wr(SCT_OFF_CTRL, 8'h74);
		wait_irq(1'b1, 600, g, n);
		wait_irq(1'b1, 600, g, n);
		chk({7'h0, n >= 195 && n <= 215}, 8'h01);
	endtask

	initial begin
		#200000;
		n_errors++;
		finish_test();
	end

	initial begin
		n_errors = 0;
		checked  = 0;
		i_arst_n = 1'b0;
		i_addr   = '0;
		i_wdata  = 8'h00;
		i_wr     = 1'b0;
		i_rd     = 1'b0;
		t_reset();
		t_levels();
		t_split_lo();
		t_flags();
		t_wide();
		t_events();
		t_sub();
		finish_test();
	end
endmodule
